// ### src/art_pkg.sv
// Package: register map, field positions and types of the auto-reload timer
`default_nettype none
package art_pkg;
  // ---------------------------------------------------------------
  // Register offsets in the internal data space
  // ---------------------------------------------------------------
  localparam logic [7:0] ART_OFS_MODE = 8'hD5;
  localparam logic [7:0] ART_OFS_FLAGS = 8'hD6;
  localparam logic [7:0] ART_OFS_CLKPS = 8'hD7;
  localparam logic [7:0] ART_OFS_RELOAD = 8'hD9;
  localparam logic [7:0] ART_OFS_COMPARE = 8'hDA;
  localparam logic [7:0] ART_OFS_LOAD = 8'hDB;
  // ---------------------------------------------------------------
  // Reset values and the last count of the divide-by-three counter
  // ---------------------------------------------------------------
  localparam logic [7:0] ART_MODE_RST = 8'h00;
  localparam logic [2:0] ART_FLAGS_RST = 3'h0;
  localparam logic [7:0] ART_CLKPS_RST = 8'h00;
  localparam logic [7:0] ART_DATA_RST = 8'h00;
  localparam logic [6:0] ART_PSC_RST = 7'h00;
  localparam logic [1:0] ART_DIV3_LAST = 2'h2;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int ART_MODE_LOAD_BIT = 7;
  localparam int ART_FLAG_EDGE_BIT = 2;
  localparam int ART_FLAG_MATCH_BIT = 1;
  localparam int ART_FLAG_ROLL_BIT = 0;
  localparam int ART_FLAG_W = 3;
  localparam int ART_PSC_W = 7;
  // ---------------------------------------------------------------
  // Modes and clock sources
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ART_MODE_RELOAD = 2'h0,
    ART_MODE_CAPTURE = 2'h1,
    ART_MODE_CAPTURE_CLR = 2'h2,
    ART_MODE_EDGE_LOAD = 2'h3
  } art_mode_t;
  typedef enum logic [1:0] {
    ART_CLK_INT = 2'h0,
    ART_CLK_INT_DIV3 = 2'h1,
    ART_CLK_PIN = 2'h2,
    ART_CLK_RSVD = 2'h3
  } art_clk_t;
  // Mode control register layout
  typedef struct packed {
    logic counter_load_bit;
    logic count_enable_bit;
    logic pulse_output_enable;
    logic edge_irq_enable;
    logic match_irq_enable;
    logic rollover_irq_enable;
    art_mode_t mode;
  } art_mode_reg_t;
  // Clock, edge and prescale register layout
  typedef struct packed {
    logic [2:0] divider_select;
    logic reserved_bit_four;
    logic edge_polarity;
    logic edge_detect_enable;
    art_clk_t clock_select;
  } art_clkps_reg_t;
  // Core access to the data space
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } art_bus_req_t;
endpackage
`default_nettype wire

// ### src/art_edge_sync.sv
// Two-stage synchroniser with rising/falling edge pulses for the timer input pin
`default_nettype none
module art_edge_sync (
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Pin
  input wire logic pin_i,
  // Edges
  output logic rise_o,
  output logic fall_o
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise_o = sync_q & ~last_q;
  assign fall_o = ~sync_q & last_q;
endmodule
`default_nettype wire

// ### src/art_timer.sv
// Auto-reload timer: registers, prescaler, counter, modes, flags and pulse output
// Function
// - Mode register clears to zero at reset
// - Load bit copies reload, clears prescaler, reads zero
// - Count enable runs; clear freezes prescaler, counter
// - Pulse pin follows waveform only when enabled
// - Edge flag and enable raise request
// - Match flag and enable raise request
// - Rollover flag and enable raise request
// - Mode field selects four operating modes
// - Flags clear on written zero, one ignored
// - Active input edge sets edge flag
// - Counter equal compare sets match flag
// - Counter wrap FFh to reload value sets rollover
// - Divider select picks 2^n, count unaffected
// - Edge enable and polarity bits control detection
// - Clock select: internal, divided by three, pin
// - Load register reads live count, writes count
// - Load register cleared to zero by reset
// - Reload register reloads counter on overflow
// - Compare register compared with counter each time the count changes
// - Load register write loads counter, clears prescaler
// - Reload mode: overflow sets pulse, match clears
// - Capture modes copy counter; reset variant clears
// - Edge-load mode copies reload on input edge
`default_nettype none
module art_timer
  import art_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Core data space access
  input wire art_bus_req_t bus_i,
  output logic [7:0] rdata_o,
  // Pins
  input wire logic timer_input_pin_i,
  output logic pulse_output_pin_o,
  // Combined timer request
  output logic irq_o
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  art_mode_reg_t mode_q;
  art_clkps_reg_t clkps_q;
  logic [ART_FLAG_W-1:0] flags_q;
  logic [ART_FLAG_W-1:0] flags_d;
  logic [CNT_W-1:0] reload_q;
  logic [CNT_W-1:0] reload_d;
  logic [CNT_W-1:0] compare_q;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic [ART_PSC_W-1:0] psc_q;
  logic [ART_PSC_W-1:0] psc_d;
  logic [1:0] div3_q;
  logic pwm_q;
  logic pwm_d;
  logic pin_q;
  logic irq_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire wr_mode = bus_i.wr && (bus_i.addr == ART_OFS_MODE);
  wire wr_flags = bus_i.wr && (bus_i.addr == ART_OFS_FLAGS);
  wire wr_clkps = bus_i.wr && (bus_i.addr == ART_OFS_CLKPS);
  wire wr_reload = bus_i.wr && (bus_i.addr == ART_OFS_RELOAD);
  wire wr_compare = bus_i.wr && (bus_i.addr == ART_OFS_COMPARE);
  wire wr_load = bus_i.wr && (bus_i.addr == ART_OFS_LOAD);
  wire [CNT_W-1:0] wdata_c = bus_i.wdata[CNT_W-1:0];
  wire art_mode_reg_t wmode = art_mode_reg_t'(bus_i.wdata);

  // ---------------------------------------------------------------
  // Input pin edges and clock source
  // ---------------------------------------------------------------
  logic pin_rise;
  logic pin_fall;

  art_edge_sync u_pin_sync (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .pin_i(timer_input_pin_i),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  wire active_edge = clkps_q.edge_polarity ? pin_fall : pin_rise;
  wire edge_evt = clkps_q.edge_detect_enable && active_edge;
  wire div3_tick = (div3_q == ART_DIV3_LAST);
  // Reserved code gives no source tick
  wire src_tick = (clkps_q.clock_select == ART_CLK_INT) ? 1'b1 :
                  (clkps_q.clock_select == ART_CLK_INT_DIV3) ? div3_tick :
                  (clkps_q.clock_select == ART_CLK_PIN) ? pin_rise : 1'b0;

  // ---------------------------------------------------------------
  // Prescaler tap: rate is source divided by 2^select
  // ---------------------------------------------------------------
  wire [ART_PSC_W:0] psc_ext = {1'b0, psc_q};
  wire [ART_PSC_W:0] tap_mask = (ART_PSC_W+1)'((1 << clkps_q.divider_select) - 1);
  wire run_tick = mode_q.count_enable_bit && src_tick;
  wire cnt_tick = run_tick && ((psc_ext & tap_mask) == tap_mask);
  wire overflow = cnt_tick && (count_q == {CNT_W{1'b1}});

  // ---------------------------------------------------------------
  // Mode actions
  // ---------------------------------------------------------------
  wire is_capture = (mode_q.mode == ART_MODE_CAPTURE) ||
                    (mode_q.mode == ART_MODE_CAPTURE_CLR);
  wire capture_evt = is_capture && edge_evt;
  wire capture_clr = (mode_q.mode == ART_MODE_CAPTURE_CLR) && edge_evt;
  wire edge_load = (mode_q.mode == ART_MODE_EDGE_LOAD) && edge_evt;
  wire bit_load = wr_mode && wmode.counter_load_bit;

  always_comb begin
    count_d = count_q;
    psc_d = psc_q;
    if (run_tick) begin
      psc_d = psc_q + 1'b1;
    end
    if (cnt_tick) begin
      count_d = overflow ? reload_q : count_q + 1'b1;
    end
    if (capture_clr) begin
      count_d = '0;
      psc_d = ART_PSC_RST;
    end
    if (edge_load || bit_load) begin
      count_d = reload_q;
      psc_d = ART_PSC_RST;
    end
    if (wr_load) begin
      count_d = wdata_c;
      psc_d = ART_PSC_RST;
    end
  end

  // Match fires as the counter arrives, so a held count cannot re-set a cleared flag
  wire count_moves = cnt_tick || capture_clr || edge_load || bit_load || wr_load;
  wire match = (count_d == compare_q);
  wire match_evt = match && count_moves;

  // Capture loads the reload register unless the core writes it the same cycle
  assign reload_d = wr_reload ? wdata_c : (capture_evt ? count_q : reload_q);

  // Pulse: overflow sets, match clears in every mode
  assign pwm_d = overflow ? 1'b1 : (match_evt ? 1'b0 : pwm_q);

  // Flags: hardware set wins over a written zero
  logic [ART_FLAG_W-1:0] set_vec;
  always_comb begin
    set_vec = '0;
    set_vec[ART_FLAG_EDGE_BIT] = edge_evt;
    set_vec[ART_FLAG_MATCH_BIT] = match_evt;
    set_vec[ART_FLAG_ROLL_BIT] = overflow;
    flags_d = set_vec | (wr_flags ? (flags_q & bus_i.wdata[ART_FLAG_W-1:0]) : flags_q);
  end

  wire irq_d = (mode_q.edge_irq_enable && flags_q[ART_FLAG_EDGE_BIT]) ||
               (mode_q.match_irq_enable && flags_q[ART_FLAG_MATCH_BIT]) ||
               (mode_q.rollover_irq_enable && flags_q[ART_FLAG_ROLL_BIT]);

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  art_mode_reg_t mode_rd;
  always_comb begin
    mode_rd = mode_q;
    mode_rd.counter_load_bit = 1'b0;
    rdata_d = 8'h00;
    unique case (bus_i.addr)
      ART_OFS_MODE: rdata_d = mode_rd;
      ART_OFS_FLAGS: rdata_d = {5'h00, flags_q};
      ART_OFS_CLKPS: rdata_d = clkps_q;
      ART_OFS_RELOAD: rdata_d = 8'(reload_q);
      ART_OFS_COMPARE: rdata_d = 8'(compare_q);
      ART_OFS_LOAD: rdata_d = 8'(count_q);
      default: rdata_d = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Flip-flops
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      mode_q <= art_mode_reg_t'(ART_MODE_RST);
      clkps_q <= art_clkps_reg_t'(ART_CLKPS_RST);
      flags_q <= ART_FLAGS_RST;
      count_q <= '0;
      psc_q <= ART_PSC_RST;
      div3_q <= 2'h0;
      pwm_q <= 1'b0;
      pin_q <= 1'b0;
      irq_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      if (wr_mode) begin
        mode_q <= wmode;
      end
      if (wr_clkps) begin
        clkps_q <= art_clkps_reg_t'(bus_i.wdata);
      end
      flags_q <= flags_d;
      count_q <= count_d;
      psc_q <= psc_d;
      div3_q <= div3_tick ? 2'h0 : div3_q + 2'h1;
      pwm_q <= pwm_d;
      pin_q <= mode_q.pulse_output_enable && pwm_d;
      irq_q <= irq_d;
      rdata_q <= bus_i.rd ? rdata_d : 8'h00;
    end
  end

  // Data registers keep their content through reset
  always_ff @(posedge clock_i) begin
    reload_q <= reload_d;
    if (wr_compare) begin
      compare_q <= wdata_c;
    end
  end

  assign rdata_o = rdata_q;
  assign pulse_output_pin_o = pin_q;
  assign irq_o = irq_q;
endmodule
`default_nettype wire

// ### verification/art_core_model.sv
// Core model: byte transfers on the timer's data space port
`default_nettype none
module art_core_model
  import art_pkg::*;
(
  // Clock
  input wire logic clock_i,
  // Data space
  output var art_bus_req_t bus_o,
  input wire logic [7:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial bus_o = '0;
  // One request per call, read data taken one cycle after the request edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    logic [7:0] m;
    m = (a == ART_OFS_CLKPS) ? 8'hEF : 8'hFF;
    @(posedge clock_i) #1 bus_o = '{addr: a, wdata: d & m, wr: w, rd: !w};
    @(posedge clock_i) #1 bus_o = '0;
    q = rdata_i;
  endtask
endmodule
`default_nettype wire

// ### verification/art_timer_monitor.sv
// Concurrent checks on the timer's ports
`default_nettype none
module art_timer_monitor
  import art_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Ports watched
  input wire art_bus_req_t bus_i,
  input wire logic [7:0] rdata_o,
  input wire logic pulse_output_pin_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // Shadow of the mode register
  logic [7:0] mode_q;
  wire logic wr_mode = bus_i.wr && bus_i.addr == ART_OFS_MODE;
  always_ff @(posedge clock_i) begin
    if (srst_i) mode_q <= ART_MODE_RST;
    else if (wr_mode) mode_q <= bus_i.wdata;
  end
  sequence s_wr(a);
    bus_i.wr && bus_i.addr == a;
  endsequence
  sequence s_rd(a);
    bus_i.rd && !bus_i.wr && bus_i.addr == a;
  endsequence
  // Write, one idle cycle, then a read of the same register
  sequence s_wr_then_rd(a);
    s_wr(a) ##1 !bus_i.wr ##1 s_rd(a);
  endsequence
  a_reset_outputs: assert property (disable iff (1'b0) srst_i |=>
    rdata_o == 8'h00 && !irq_o && !pulse_output_pin_o) else $error("outputs not cleared");
  a_mode_read_back: assert property (s_wr_then_rd(ART_OFS_MODE) |=>
    rdata_o == ($past(bus_i.wdata, 3) & 8'h7F)) else $error("mode read back wrong");
  a_load_bit_zero: assert property (s_rd(ART_OFS_MODE) |=>
    !rdata_o[ART_MODE_LOAD_BIT]) else $error("load bit reads one");
  a_cfg_read_back: assert property ((s_wr(ART_OFS_CLKPS) or s_wr(ART_OFS_COMPARE))
    ##1 !bus_i.wr ##1 (bus_i.rd && !bus_i.wr && bus_i.addr == $past(bus_i.addr, 2)) |=>
    rdata_o == $past(bus_i.wdata, 3)) else $error("config read back wrong");
  a_load_live: assert property ((s_wr(ART_OFS_LOAD) ##0 (mode_q[6:0] == 7'h00))
    ##1 !bus_i.wr ##1 s_rd(ART_OFS_LOAD) |=> rdata_o == $past(bus_i.wdata, 3))
    else $error("held counter lost load");
  a_pulse_masked: assert property ((!mode_q[5]) [*3] |-> !pulse_output_pin_o)
    else $error("pulse while disabled");
  a_irq_masked: assert property ((mode_q[4:2] == 3'h0) [*3] |-> !irq_o)
    else $error("request while masked");
  a_irq_raised: assert property (s_rd(ART_OFS_FLAGS) ##1
    (!bus_i.wr && (rdata_o[2:0] & mode_q[4:2]) != 3'h0) |-> ##[0:1] irq_o)
    else $error("request missing");
endmodule
bind art_timer art_timer_monitor #(.CNT_W(CNT_W)) u_mon (.clock_i(clock_i),
  .srst_i(srst_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .pulse_output_pin_o(pulse_output_pin_o), .irq_o(irq_o));
`default_nettype wire

// ### verification/art_timer_test.sv
// Self-checking bench for the auto-reload timer
`default_nettype none
module art_timer_test import art_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic pin = 1'b0;
  art_bus_req_t bus;
  logic [7:0] rdata;
  logic pulse;
  logic irq;
  int n_fail = 0;
  int checked = 0;
  always #10 clock_i = ~clock_i;
  art_timer DUT (.clock_i(clock_i), .srst_i(srst_i), .bus_i(bus), .rdata_o(rdata),
    .timer_input_pin_i(pin), .pulse_output_pin_o(pulse), .irq_o(irq));
  art_core_model u_core (.clock_i(clock_i), .bus_o(bus), .rdata_i(rdata));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_core.xfer(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] q;
    u_core.xfer(1'b0, a, 8'h00, q);
    check(q & m, e);
  endtask
  task automatic pin_to(input logic v);
    pin = v;
    cyc(6);
  endtask
  task automatic results;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_regs;
    rd_chk(ART_OFS_MODE, 8'hFF, 8'h00);
    rd_chk(ART_OFS_FLAGS, 8'h07, 8'h00);
    wr(ART_OFS_COMPARE, 8'hA5);
    rd_chk(ART_OFS_COMPARE, 8'hFF, 8'hA5);
    wr(ART_OFS_RELOAD, 8'h00);
    wr(ART_OFS_MODE, 8'hBC);
    rd_chk(ART_OFS_MODE, 8'hFF, 8'h3C);
    rd_chk(8'hD8, 8'hFF, 8'h00);
  endtask
  task automatic t_count;
    logic [7:0] cfg [6] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h01, 8'h03};
    int span [6] = '{16, 16, 16, 16, 48, 16};
    logic [7:0] step [6] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h10, 8'h00};
    logic [7:0] a;
    logic [7:0] b;
    for (int i = 0; i < 6; i++) begin
      wr(ART_OFS_CLKPS, cfg[i]);
      wr(ART_OFS_MODE, 8'h40);
      u_core.xfer(1'b0, ART_OFS_LOAD, 8'h00, a);
      cyc(span[i] - 2);
      u_core.xfer(1'b0, ART_OFS_LOAD, 8'h00, b);
      check(b - a, step[i]);
    end
    wr(ART_OFS_CLKPS, 8'h02);
    u_core.xfer(1'b0, ART_OFS_LOAD, 8'h00, a);
    repeat (4) begin
      pin_to(1'b1);
      pin_to(1'b0);
    end
    u_core.xfer(1'b0, ART_OFS_LOAD, 8'h00, b);
    check(b - a, 8'h04);
    wr(ART_OFS_CLKPS, 8'h00);
    wr(ART_OFS_MODE, 8'h00);
    wr(ART_OFS_LOAD, 8'h10);
    rd_chk(ART_OFS_LOAD, 8'hFF, 8'h10);
    cyc(15);
    rd_chk(ART_OFS_LOAD, 8'hFF, 8'h10);
  endtask
  task automatic t_overflow;
    wr(ART_OFS_COMPARE, 8'h80);
    wr(ART_OFS_FLAGS, 8'h00);
    wr(ART_OFS_LOAD, 8'hFA);
    wr(ART_OFS_MODE, 8'h44);
    cyc(10);
    rd_chk(ART_OFS_FLAGS, 8'h01, 8'h01);
    check({7'h00, irq}, 8'h01);
    wr(ART_OFS_MODE, 8'h04);
    wr(ART_OFS_FLAGS, 8'h07);
    rd_chk(ART_OFS_FLAGS, 8'h01, 8'h01);
    wr(ART_OFS_FLAGS, 8'h06);
    cyc(2);
    check({7'h00, irq}, 8'h00);
  endtask
  task automatic t_pwm;
    logic [7:0] h;
    wr(ART_OFS_COMPARE, 8'h40);
    wr(ART_OFS_LOAD, 8'h00);
    wr(ART_OFS_MODE, 8'h60);
    cyc(300);
    h = 8'h00;
    repeat (512) begin
      @(posedge clock_i) #1 h = h + {7'h00, pulse};
    end
    check(h, 8'h80);
    rd_chk(ART_OFS_FLAGS, 8'h02, 8'h02);
  endtask
  task automatic t_edge;
    wr(ART_OFS_MODE, 8'h00);
    wr(ART_OFS_FLAGS, 8'h00);
    wr(ART_OFS_LOAD, 8'h5A);
    wr(ART_OFS_CLKPS, 8'h04);
    wr(ART_OFS_MODE, 8'h11);
    pin_to(1'b1);
    rd_chk(ART_OFS_FLAGS, 8'h04, 8'h04);
    check({7'h00, irq}, 8'h01);
    rd_chk(ART_OFS_RELOAD, 8'hFF, 8'h5A);
    wr(ART_OFS_CLKPS, 8'h0C);
    wr(ART_OFS_LOAD, 8'h3C);
    pin_to(1'b0);
    rd_chk(ART_OFS_RELOAD, 8'hFF, 8'h3C);
    wr(ART_OFS_CLKPS, 8'h08);
    wr(ART_OFS_LOAD, 8'h11);
    pin_to(1'b1);
    pin_to(1'b0);
    rd_chk(ART_OFS_RELOAD, 8'hFF, 8'h3C);
    wr(ART_OFS_CLKPS, 8'h04);
    wr(ART_OFS_MODE, 8'h02);
    wr(ART_OFS_LOAD, 8'h77);
    pin_to(1'b1);
    rd_chk(ART_OFS_RELOAD, 8'hFF, 8'h77);
    rd_chk(ART_OFS_LOAD, 8'hFF, 8'h00);
    wr(ART_OFS_RELOAD, 8'h33);
    wr(ART_OFS_MODE, 8'h03);
    pin_to(1'b0);
    pin_to(1'b1);
    rd_chk(ART_OFS_LOAD, 8'hFF, 8'h33);
  endtask
  task automatic t_reset;
    wr(ART_OFS_RELOAD, 8'h5C);
    wr(ART_OFS_MODE, 8'h64);
    cyc(1);
    srst_i = 1'b1;
    cyc(3);
    srst_i = 1'b0;
    rd_chk(ART_OFS_MODE, 8'hFF, 8'h00);
    rd_chk(ART_OFS_FLAGS, 8'h07, 8'h00);
    rd_chk(ART_OFS_LOAD, 8'hFF, 8'h00);
    rd_chk(ART_OFS_RELOAD, 8'hFF, 8'h5C);
  endtask
  initial begin
    cyc(20);
    srst_i = 1'b0;
    t_regs();
    t_count();
    t_overflow();
    t_pwm();
    t_edge();
    t_reset();
    results();
  end
  initial begin
    cyc(20000);
    n_fail++;
    results();
  end
endmodule
`default_nettype wire
